// ==== design/dscr_defs.vh ====
`ifndef DSCR_DEFS_VH
`define DSCR_DEFS_VH
// Register word offsets
`define DSCR_ADDR_RUN_CMD 16'h0006
`define DSCR_ADDR_OP_STATUS 16'h000E
`define DSCR_ADDR_TRIP 16'h000F
`define DSCR_ADDR_DIN 16'h0010
`define DSCR_ADDR_DOUT 16'h0011
`define DSCR_ADDR_VIN1 16'h0012
`define DSCR_ADDR_VIN2 16'h0013
`define DSCR_ADDR_IIN 16'h0014
`define DSCR_ADDR_RPM 16'h0015
`define DSCR_ADDR_UNIT 16'h001A
`define DSCR_ADDR_POLES 16'h001B
`define DSCR_ADDR_CUSTVER 16'h001C
// Command bit positions
`define DSCR_CMD_STOP 0
`define DSCR_CMD_FWD 1
`define DSCR_CMD_REV 2
`define DSCR_CMD_FRESET 3
`define DSCR_CMD_ESTOP 4
`define DSCR_CMD_WIDTH 5
// Writable command bits mask (bit 5 unused)
`define DSCR_CMD_WMASK 16'h001F
`define DSCR_ZERO16 16'h0000
// Reserved trip bits 5, 9 and 11 read low
`define DSCR_TRIP_MASK 16'hF5DF
`endif

// ==== design/dscr_sync.v ====
`timescale 1ns/1ps
module dscr_sync #(
  parameter WIDTH = 1
) (
  input wire clock_in,
  input wire reset_in,
  input wire enable_in,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  // Two stages; first stage read by second only
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      meta_q <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (enable_in) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ==== design/dscr_regs.v ====
`timescale 1ns/1ps
`include "dscr_defs.vh"
// Summary of operation
// - Status bit 6 shows speed arrival, bit 7 DC braking and bit 8 stopping.
// - Status bit 10 is brake open, 11 forward command pending, 12 reverse, bit 9 reads 0.
// - Status bit 13 marks remote run source, bit 14 remote speed source.
// - Trip bits 0-4 are overcurrent, overvoltage, external fault A, base block, low bus.
// - Trip bit 6 is earth fault or heatsink hot, 7 motor thermal, 8 overload, 10 self check.
// - Trip bits 12-15 are second overcurrent, addon card, phase loss, drive overload.
// - Input status bits 0-7 mirror the eight multi-function inputs, upper bits zero.
// - Output status bits 0-3 mirror relay outputs, bit 7 the fault relay contact.
// - A 0-to-1 write on command bit 0 requests a stop once.
// - A 0-to-1 write on command bit 1 starts a forward run once.
// - A 0-to-1 write on command bit 2 starts a reverse run once.
// - A 0-to-1 write on command bit 3 clears latched trips once.
// - Status bits 0-5 show stopped, forward, reverse, tripped, accelerating, decelerating.
// - A 0-to-1 write on command bit 4 triggers an emergency stop; bit 5 is unused.
module dscr_regs #(
  parameter ADDR_WIDTH = 16,
  parameter ANALOG_WIDTH = 16
) (
  input wire clock_in,
  input wire reset_in,
  input wire enable_in,
  // Register access from the serial front end (same clock)
  input wire reg_write_in,
  input wire reg_read_in,
  input wire [ADDR_WIDTH-1:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  output reg [15:0] reg_rdata_out,
  output reg reg_rvalid_out,
  output reg reg_error_out,
  // Drive state from control core (same clock)
  input wire stopped_in,
  input wire fwd_running_in,
  input wire rev_running_in,
  input wire tripped_in,
  input wire accelerating_in,
  input wire decelerating_in,
  input wire speed_arrival_in,
  input wire dc_braking_in,
  input wire stopping_in,
  input wire brake_open_in,
  input wire fwd_cmd_pending_in,
  input wire rev_cmd_pending_in,
  input wire remote_run_source_in,
  input wire remote_speed_source_in,
  input wire [15:0] trip_cause_in,
  input wire [ANALOG_WIDTH-1:0] voltage_input_one_in,
  input wire [ANALOG_WIDTH-1:0] voltage_input_two_in,
  input wire [ANALOG_WIDTH-1:0] current_input_in,
  input wire [15:0] motor_speed_rpm_in,
  input wire display_unit_rpm_in,
  input wire [15:0] motor_pole_count_in,
  input wire [15:0] custom_version_in,
  // Terminal pins (asynchronous)
  input wire [7:0] multi_input_in,
  input wire [3:0] relay_output_in,
  input wire fault_relay_contact_in,
  // One-cycle command pulses
  output reg stop_req_out,
  output reg fwd_run_req_out,
  output reg rev_run_req_out,
  output reg fault_reset_req_out,
  output reg estop_req_out
);
  ////////////////////////////////////////////////////////////////
  wire [7:0] din_sync;
  wire [4:0] dout_sync;
  reg [`DSCR_CMD_WIDTH-1:0] cmd_q;
  reg [`DSCR_CMD_WIDTH-1:0] cmd_d;
  reg [`DSCR_CMD_WIDTH-1:0] rise_d;
  reg [15:0] rdata_d;
  reg hit_d;
  wire cmd_wr;

  dscr_sync #(.WIDTH(8)) u_din_sync (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .enable_in(enable_in),
    .async_in(multi_input_in),
    .sync_out(din_sync)
  );

  dscr_sync #(.WIDTH(5)) u_dout_sync (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .enable_in(enable_in),
    .async_in({fault_relay_contact_in, relay_output_in}),
    .sync_out(dout_sync)
  );

  ////////////////////////////////////////////////////////////////
  // Command register: only address 0x0006 is writable
  assign cmd_wr = reg_write_in && (reg_addr_in == `DSCR_ADDR_RUN_CMD);

  always @* begin
    cmd_d = cmd_q;
    rise_d = {`DSCR_CMD_WIDTH{1'b0}};
    if (cmd_wr) begin
      cmd_d = reg_wdata_in[`DSCR_CMD_WIDTH-1:0];
      // Edge against the stored value, so a held level never repeats
      rise_d = reg_wdata_in[`DSCR_CMD_WIDTH-1:0] & ~cmd_q;
    end
  end

  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cmd_q <= {`DSCR_CMD_WIDTH{1'b0}};
      stop_req_out <= 1'b0;
      fwd_run_req_out <= 1'b0;
      rev_run_req_out <= 1'b0;
      fault_reset_req_out <= 1'b0;
      estop_req_out <= 1'b0;
    end else if (enable_in) begin
      cmd_q <= cmd_d;
      stop_req_out <= rise_d[`DSCR_CMD_STOP];
      fwd_run_req_out <= rise_d[`DSCR_CMD_FWD];
      rev_run_req_out <= rise_d[`DSCR_CMD_REV];
      fault_reset_req_out <= rise_d[`DSCR_CMD_FRESET];
      estop_req_out <= rise_d[`DSCR_CMD_ESTOP];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read mux
  always @* begin
    rdata_d = `DSCR_ZERO16;
    hit_d = 1'b1;
    case (reg_addr_in)
      `DSCR_ADDR_RUN_CMD: rdata_d = {11'h000, cmd_q};
      `DSCR_ADDR_OP_STATUS: rdata_d = {1'b0,
                                      remote_speed_source_in,
                                      remote_run_source_in,
                                      rev_cmd_pending_in,
                                      fwd_cmd_pending_in,
                                      brake_open_in,
                                      1'b0,
                                      stopping_in,
                                      dc_braking_in,
                                      speed_arrival_in,
                                      decelerating_in,
                                      accelerating_in,
                                      tripped_in,
                                      rev_running_in,
                                      fwd_running_in,
                                      stopped_in};
      // Reserved trip bits 5, 9 and 11 forced low
      `DSCR_ADDR_TRIP: rdata_d = trip_cause_in & `DSCR_TRIP_MASK;
      `DSCR_ADDR_DIN: rdata_d = {8'h00, din_sync};
      `DSCR_ADDR_DOUT: rdata_d = {8'h00, dout_sync[4], 3'h0, dout_sync[3:0]};
      `DSCR_ADDR_VIN1: rdata_d = voltage_input_one_in[15:0];
      `DSCR_ADDR_VIN2: rdata_d = voltage_input_two_in[15:0];
      `DSCR_ADDR_IIN: rdata_d = current_input_in[15:0];
      `DSCR_ADDR_RPM: rdata_d = motor_speed_rpm_in;
      `DSCR_ADDR_UNIT: rdata_d = {15'h0000, display_unit_rpm_in};
      `DSCR_ADDR_POLES: rdata_d = motor_pole_count_in;
      `DSCR_ADDR_CUSTVER: rdata_d = custom_version_in;
      default: hit_d = 1'b0;
    endcase
  end

  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= `DSCR_ZERO16;
      reg_rvalid_out <= 1'b0;
      reg_error_out <= 1'b0;
    end else if (enable_in) begin
      reg_rvalid_out <= reg_read_in;
      reg_rdata_out <= reg_read_in ? rdata_d : `DSCR_ZERO16;
      // Unmapped read, or write to anything but the command word
      reg_error_out <= (reg_read_in && !hit_d) || (reg_write_in && !cmd_wr);
    end
  end
endmodule

// ==== verification/dscr_regs_sva.sv ====
`timescale 1ns/1ps
module dscr_regs_chk (
  input wire clock_in,
  input wire reset_in,
  input wire enable_in,
  input wire reg_write_in,
  input wire reg_read_in,
  input wire [15:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire [15:0] reg_rdata_out,
  input wire reg_rvalid_out,
  input wire reg_error_out,
  input wire stop_req_out,
  input wire fwd_run_req_out,
  input wire rev_run_req_out,
  input wire fault_reset_req_out,
  input wire estop_req_out
);
  // Shadow of the stored command, so edges are judged against it
  logic [4:0] cmd_q;
  wire wr_cmd = enable_in && reg_write_in && reg_addr_in == 16'h0006;
  wire [4:0] rise = wr_cmd ? reg_wdata_in[4:0] & ~cmd_q : 5'h00;
  wire [4:0] req = {estop_req_out, fault_reset_req_out, rev_run_req_out, fwd_run_req_out,
    stop_req_out};
  always @(posedge clock_in or posedge reset_in)
    if (reset_in) cmd_q <= 5'h00;
    else if (wr_cmd) cmd_q <= reg_wdata_in[4:0];
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  sequence s_rd;
    enable_in && reg_read_in;
  endsequence
  a_stop_edge: assert property (req[0] == $past(rise[0])) else $error("stop");
  a_fwd_edge: assert property (req[1] == $past(rise[1])) else $error("fwd");
  a_rev_edge: assert property (req[2] == $past(rise[2])) else $error("rev");
  a_reset_edge: assert property (req[3] == $past(rise[3])) else $error("reset");
  a_estop_edge: assert property (req[4] == $past(rise[4])) else $error("estop");
  a_read_answer: assert property (s_rd |=> reg_rvalid_out) else $error("rvalid");
  a_ro_refused: assert property (reg_write_in && enable_in && !wr_cmd |=> reg_error_out)
    else $error("ro write");
  a_trip_gap: assert property (s_rd ##0 reg_addr_in == 16'h000F |=>
    (reg_rdata_out & 16'h0A20) == 16'h0000) else $error("trip gap");
endmodule
////////////////////////////////////////////////////////////////
bind dscr_regs dscr_regs_chk dscr_regs_chk_inst (.*);

// ==== verification/dscr_master.sv ====
`timescale 1ns/1ps
module dscr_master (
  input wire clock_in,
  input wire [15:0] rdata_in,
  input wire error_in,
  output logic wr_out = 1'b0,
  output logic rd_out = 1'b0,
  output logic [15:0] addr_out = 16'h0000,
  output logic [15:0] data_out = 16'h0000
);
  // Inverse after release, so a stale bus value cannot pass
  task automatic xfer(input logic w, input logic [15:0] a, d, output logic [16:0] q);
    @(posedge clock_in) #1;
    {wr_out, rd_out, addr_out, data_out} = {w, !w, a, d};
    @(posedge clock_in) #1;
    {wr_out, rd_out, addr_out, data_out} = {2'b00, ~a, ~d};
    q = {error_in, rdata_in};
  endtask
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic enable_in = 1'b1;
  wire reg_write_in, reg_read_in, reg_rvalid_out, reg_error_out;
  wire [15:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  wire [4:0] req;
  logic [13:0] st;
  logic [15:0] trip, va, vb, ci, rpm, poles, ver;
  logic [7:0] mi;
  logic [4:0] ro;
  logic unit;
  logic [16:0] q;
  logic [7:0] pc [5] = '{default: 8'h00};
  logic [31:0] seed = 32'h0000000E;
  int num_errors = 0;
  int n_checks = 0;
  dscr_master dscr_master_inst (.clock_in, .rdata_in(reg_rdata_out), .error_in(reg_error_out),
    .wr_out(reg_write_in), .rd_out(reg_read_in), .addr_out(reg_addr_in), .data_out(reg_wdata_in));
  dscr_regs dscr_regs_inst (.*, .stopped_in(st[0]), .fwd_running_in(st[1]), .rev_running_in(st[2]),
    .tripped_in(st[3]), .accelerating_in(st[4]), .decelerating_in(st[5]),
    .speed_arrival_in(st[6]), .dc_braking_in(st[7]), .stopping_in(st[8]), .brake_open_in(st[9]),
    .fwd_cmd_pending_in(st[10]), .rev_cmd_pending_in(st[11]), .remote_run_source_in(st[12]),
    .remote_speed_source_in(st[13]), .trip_cause_in(trip), .voltage_input_one_in(va),
    .voltage_input_two_in(vb), .current_input_in(ci), .motor_speed_rpm_in(rpm),
    .display_unit_rpm_in(unit), .motor_pole_count_in(poles), .custom_version_in(ver),
    .multi_input_in(mi), .relay_output_in(ro[3:0]), .fault_relay_contact_in(ro[4]),
    .stop_req_out(req[0]), .fwd_run_req_out(req[1]), .rev_run_req_out(req[2]),
    .fault_reset_req_out(req[3]), .estop_req_out(req[4]));
  initial forever #2 clock_in = ~clock_in;
  always @(posedge clock_in) foreach (pc[i]) pc[i] <= pc[i] + 8'(req[i]);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task setin();
    {st, unit, mi, ro} = 28'(rnd());
    {trip, va} = rnd();
    {vb, ci} = rnd();
    {rpm, poles} = rnd();
    ver = 16'(rnd());
  endtask
  // Unmapped places answer zero with the error flag
  function automatic logic [16:0] expv(logic [15:0] a, logic [4:0] c);
    case (a)
      16'h0006: return {12'h000, c};
      16'h000E: return {2'b00, st[13:9], 1'b0, st[8:0]};
      16'h000F: return {1'b0, trip & 16'hF5DF};
      16'h0010: return {9'h000, mi};
      16'h0011: return {9'h000, ro[4], 3'h0, ro[3:0]};
      16'h0012: return {1'b0, va};
      16'h0013: return {1'b0, vb};
      16'h0014: return {1'b0, ci};
      16'h0015: return {1'b0, rpm};
      16'h001A: return {16'h0000, unit};
      16'h001B: return {1'b0, poles};
      16'h001C: return {1'b0, ver};
      default: return 17'h10000;
    endcase
  endfunction
  task bus(logic w, logic [15:0] a, d);
    dscr_master_inst.xfer(w, a, d, q);
    chk("rvalid", 17'(!w && enable_in), 17'(reg_rvalid_out));
  endtask
  task chk(string nm, logic [16:0] e, s);
    n_checks++;
    if (e !== s) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #20us;
    num_errors++;
    finish_test();
  end
  initial begin
    setin();
    repeat (10) @(posedge clock_in);
    #1 reset_in = 1'b0;
    repeat (4) begin
      @(posedge clock_in) #1 setin();
      // Pins need two synchroniser edges before reads see them
      repeat (3) @(posedge clock_in);
      for (int a = 6; a < 30; a++) begin
        bus(1'b0, 16'(a), 16'h0000);
        chk("read", expv(16'(a), 5'h00), q);
      end
      bus(1'b1, 16'h000F, ~trip);
      chk("ro write", 17'h10000, q);
      bus(1'b0, 16'h000F, 16'h0000);
      chk("ro keep", expv(16'h000F, 5'h00), q);
    end
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 16'h0006, 16'h0001 << i);
      bus(1'b1, 16'h0006, 16'hFFE0 | (16'h0001 << i));
      bus(1'b0, 16'h0006, 16'h0000);
      chk("cmd", expv(16'h0006, 5'(1 << i)), q);
      bus(1'b1, 16'h0006, 16'h0000);
    end
    // Frozen cycle: a rising write must not pulse
    enable_in = 1'b0;
    bus(1'b1, 16'h0006, 16'h0002);
    bus(1'b0, 16'h0006, 16'h0000);
    enable_in = 1'b1;
    bus(1'b0, 16'h0006, 16'h0000);
    chk("frozen cmd", expv(16'h0006, 5'h00), q);
    foreach (pc[i]) chk("pulses", 17'h00001, 17'(pc[i]));
    finish_test();
  end
endmodule
